// ===== core/pmcc_cfg.svh
`ifndef PMCC_CFG_SVH
`define PMCC_CFG_SVH

// Register byte offsets
`define PMCC_OFS_GATE 5'h00
`define PMCC_OFS_SLOW 5'h04
`define PMCC_OFS_BUSDIV 5'h08
`define PMCC_OFS_CLKOUT 5'h0c
`define PMCC_OFS_LOCK 5'h10
`define PMCC_OFS_STATUS 5'h14

// Field positions
`define PMCC_GATE_IDLE_BIT 2
`define PMCC_GATE_OFF_BIT 3
`define PMCC_GATE_PERIPH_LSB 8
`define PMCC_SLOW_DIVIDER_VALUE_LSB 0
`define PMCC_SLOW_BIT 4
`define PMCC_SLOW_PLL_OFF_BIT 5
`define PMCC_BUSDIV_APB_BIT 0
`define PMCC_BUSDIV_AHB_BIT 1
`define PMCC_CLKOUT_SEL_LSB 4
`define PMCC_STAT_MODE_LSB 0
`define PMCC_STAT_LOCK_BIT 2
`define PMCC_STAT_BATT_BIT 3
`define PMCC_STAT_WAKE_BIT 4

// Reset values
`define PMCC_RST_PERIPH_GATE 24'hffffff
`define PMCC_RST_CLKOUT_SEL 3'h0

// Mode codes in the status register
`define PMCC_MODE_NORMAL 2'h0
`define PMCC_MODE_SLOW 2'h1
`define PMCC_MODE_IDLE 2'h2
`define PMCC_MODE_OFF 2'h3

// Clock output select codes
`define PMCC_CO_MPLL 3'h0
`define PMCC_CO_UPLL 3'h1
`define PMCC_CO_CPU 3'h2
`define PMCC_CO_AHB 3'h3
`define PMCC_CO_APB 3'h4
`define PMCC_CO_DIVIDED_CLOCK_ZERO 3'h5

// Slow divider
`define PMCC_DIV_UNITY 4'h1
`define PMCC_DIV_ZERO 3'h0

// Timing
`define PMCC_CLK_PERIOD_NS 20
`define PMCC_LOCK_TIME_NS 150000
`define PMCC_LOCK_CYCLES ((`PMCC_LOCK_TIME_NS + `PMCC_CLK_PERIOD_NS - 1) / `PMCC_CLK_PERIOD_NS)
`define PMCC_WAKE_RST_CYCLES 65535

`endif

// ===== core/pmcc_clkdiv.sv
`timescale 1ns/100ps
`include "pmcc_cfg.svh"

module pmcc_clkdiv import pmcc_pkg::*; (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic run,
  input wire pmcc_slow_cfg_t cfg,
  output logic cpu_tick,
  output logic ahb_tick,
  output logic apb_tick
);

  logic [3:0] cnt_r, cnt_nxt;
  logic [3:0] limit;
  logic cpu_tick_r, cpu_tick_nxt;
  logic ahb_tick_r, ahb_tick_nxt;
  logic apb_tick_r, apb_tick_nxt;
  logic ahb_ph_r, ahb_ph_nxt;
  logic apb_ph_r, apb_ph_nxt;

  // Divider ratio and tick chain
  always_comb begin
    limit = (cfg.slow_divider_value == `PMCC_DIV_ZERO) ? `PMCC_DIV_UNITY : {cfg.slow_divider_value, 1'b0};
    cnt_nxt = '0;
    cpu_tick_nxt = 1'b0;
    ahb_tick_nxt = 1'b0;
    apb_tick_nxt = 1'b0;
    ahb_ph_nxt = ahb_ph_r;
    apb_ph_nxt = apb_ph_r;
    if (run) begin
      if (cnt_r >= limit - `PMCC_DIV_UNITY) begin
        cpu_tick_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + `PMCC_DIV_UNITY;
      end
      ahb_tick_nxt = cpu_tick_nxt & (~cfg.ahb_half_option | ahb_ph_r);
      if (cpu_tick_nxt && cfg.ahb_half_option) begin
        ahb_ph_nxt = ~ahb_ph_r;
      end
      apb_tick_nxt = ahb_tick_nxt & (~cfg.apb_half_option | apb_ph_r);
      if (ahb_tick_nxt && cfg.apb_half_option) begin
        apb_ph_nxt = ~apb_ph_r;
      end
    end else begin
      ahb_ph_nxt = 1'b0;
      apb_ph_nxt = 1'b0;
    end
  end

  // Divider state
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_r <= '0;
      cpu_tick_r <= 1'b0;
      ahb_tick_r <= 1'b0;
      apb_tick_r <= 1'b0;
      ahb_ph_r <= 1'b0;
      apb_ph_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      cpu_tick_r <= cpu_tick_nxt;
      ahb_tick_r <= ahb_tick_nxt;
      apb_tick_r <= apb_tick_nxt;
      ahb_ph_r <= ahb_ph_nxt;
      apb_ph_r <= apb_ph_nxt;
    end
  end

  assign cpu_tick = cpu_tick_r;
  assign ahb_tick = ahb_tick_r;
  assign apb_tick = apb_tick_r;

  a_div_unity_run: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (run && $past(run) && cfg.slow_divider_value == 3'h0 && $past(cfg.slow_divider_value) == 3'h0) |-> cpu_tick_r)
    else $error("slow divide by one does not tick every cycle");

  a_div_two_gap: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (run && cfg.slow_divider_value == 3'h1 && cpu_tick_r) ##1 (run && cfg.slow_divider_value == 3'h1)
    |-> !cpu_tick_r ##1 (cpu_tick_r || !run || cfg.slow_divider_value != 3'h1))
    else $error("slow divide by two period wrong");

  a_ahb_apb_nest: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (apb_tick_r |-> ahb_tick_r) and (ahb_tick_r |-> cpu_tick_r))
    else $error("bus tick outside parent tick");

  a_ahb_half_skip: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (cfg.ahb_half_option && ahb_tick_r) ##1 (cfg.ahb_half_option && cpu_tick_r) |-> !ahb_tick_r)
    else $error("halved bus tick on consecutive cpu ticks");

endmodule // pmcc_clkdiv

// ===== core/pmcc_pkg.sv
package pmcc_pkg;

  // Power mode sequencer states
  typedef enum logic [2:0] {
    ST_NORMAL = 3'b000,
    ST_SLOW = 3'b001,
    ST_LOCK = 3'b010,
    ST_IDLE_WAIT = 3'b011,
    ST_IDLE = 3'b100,
    ST_OFF = 3'b101,
    ST_WAKE = 3'b110
  } pmcc_state_t;

  // Slow clock divider settings
  typedef struct packed {
    logic [2:0] slow_divider_value;
    logic ahb_half_option;
    logic apb_half_option;
  } pmcc_slow_cfg_t;

  // Per-pin configuration from the pin mux
  typedef struct packed {
    logic gpio_sel;
    logic gpio_dir_out;
    logic bidir;
    logic gpio_data;
    logic func_level;
    logic func_en;
  } pmcc_pin_cfg_t;

endpackage

// ===== core/pmcc_top.sv
// Overview of operation
// - Four power modes: normal, slow, idle, power-off.
// - Normal mode clocks everything; software gates each peripheral clock.
// - Slow CPU clock is raw input divided by 1, or twice the 3-bit value.
// - AHB equals CPU or half; APB equals AHB or half.
// - Slow mode with PLL off powers the PLL down.
// - Slow with PLL off to normal inserts a programmable PLL lock wait.
// - During the lock wait the CPU runs from the slow clock.
// - Slow bit with PLL on also gives the slow clock while slow lasts.
// - Idle stops only the CPU clock; others keep running.
// - Any CPU interrupt ends idle and restarts the CPU clock.
// - Power-off drops the core power enable output.
// - Power-off ends only on an external wake input event.
// - Power-off pins: GPIO out drives data unless bidir, inputs stay, function outputs hold.
// - Only defined mode transitions are taken; others are refused.
// - Power-off removes CPU and bus clocks, holds function pins, waits for wake.
// - Outside power-off a low battery fault raises a level interrupt.
// - In power-off a battery fault masks every wake source.
// - Clock out select routes six sources for codes 0 to 5.
// - Idle is entered only after the CPU wrapper acknowledges.
// - Wake from power-off holds internal reset for 65535 input clocks.
`timescale 1ns/100ps
`include "pmcc_cfg.svh"

module pmcc_top import pmcc_pkg::*; #(
  parameter int NUM_PERIPH = 8,
  parameter int NUM_PINS = 8,
  parameter int LOCK_CYCLES = `PMCC_LOCK_CYCLES,
  parameter int WAKE_RST_CYCLES = `PMCC_WAKE_RST_CYCLES
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic cpu_irq,
  input wire logic cpu_idle_ack,
  input wire logic [15:0] external_wake_inputs,
  input wire logic battery_fault_n,
  input wire logic main_pll_clock,
  input wire logic usb_pll_clock,
  input wire logic divided_clock_zero,
  input wire pmcc_pin_cfg_t [NUM_PINS-1:0] pin_cfg,
  output logic cpu_core_clock_en,
  output logic cpu_clock_from_pll,
  output logic ahb_clock_en,
  output logic apb_clock_en,
  output logic [NUM_PERIPH-1:0] periph_clock_en,
  output logic pll_power_down,
  output logic idle_request,
  output logic core_power_enable,
  output logic internal_reset,
  output logic battery_irq,
  output logic clock_out_port,
  output logic [NUM_PINS-1:0] pad_out,
  output logic [NUM_PINS-1:0] pad_oe
);

  localparam int WW = $clog2(WAKE_RST_CYCLES + 1);

  // Parameter sanity
  if (NUM_PERIPH < 1 || NUM_PERIPH > 32 - `PMCC_GATE_PERIPH_LSB) begin : g_bad_periph
    $error("NUM_PERIPH out of range");
  end
  if (LOCK_CYCLES < 1 || LOCK_CYCLES > 65535 || WAKE_RST_CYCLES < 1) begin : g_bad_time
    $error("timing counts out of range");
  end

  // Bus slave, configuration and status state
  logic wait_r, wait_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [NUM_PERIPH-1:0] gate_r, gate_nxt;
  logic idle_bit_r, idle_bit_nxt;
  logic off_bit_r, off_bit_nxt;
  logic [2:0] slow_divider_value_r, slow_divider_value_nxt;
  logic slow_bit_r, slow_bit_nxt;
  logic pll_off_r, pll_off_nxt;
  logic ahb_half_r, ahb_half_nxt;
  logic apb_half_r, apb_half_nxt;
  logic [2:0] clksel_r, clksel_nxt;
  logic [15:0] lock_time_r, lock_time_nxt;
  logic wake_seen_r, wake_seen_nxt;
  logic [31:0] img, wimg;
  logic wr_ok;

  // Mode sequencer state
  pmcc_state_t state_r, state_nxt;
  logic [15:0] lock_cnt_r, lock_cnt_nxt;
  logic [WW-1:0] wake_cnt_r, wake_cnt_nxt;
  logic idle_done, wake_done, wake_any;

  // Output flops
  logic cpu_en_r, cpu_en_nxt;
  logic cpu_pll_r, cpu_pll_nxt;
  logic ahb_en_r, ahb_en_nxt;
  logic apb_en_r, apb_en_nxt;
  logic [NUM_PERIPH-1:0] pclk_en_r, pclk_en_nxt;
  logic pll_pd_r, pll_pd_nxt;
  logic idle_req_r, idle_req_nxt;
  logic pwr_en_r, pwr_en_nxt;
  logic int_rst_r, int_rst_nxt;
  logic batt_irq_r, batt_irq_nxt;
  logic clkout_r, clkout_nxt;
  logic [NUM_PINS-1:0] pad_out_r, pad_out_nxt;
  logic [NUM_PINS-1:0] pad_oe_r, pad_oe_nxt;

  // Slow divider ticks
  pmcc_slow_cfg_t slow_cfg;
  logic slow_run, cpu_tick, ahb_tick, apb_tick;

  // Byte-lane merge of a write into a register image
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction

  assign wr_ok = avs_write & ~wait_r;
  assign wake_any = |external_wake_inputs;

  // Register file: read image, writes, hardware updates
  always_comb begin
    img = '0;
    case (avs_address)
      `PMCC_OFS_GATE: begin
        img[`PMCC_GATE_PERIPH_LSB +: NUM_PERIPH] = gate_r;
        img[`PMCC_GATE_IDLE_BIT] = idle_bit_r;
        img[`PMCC_GATE_OFF_BIT] = off_bit_r;
      end
      `PMCC_OFS_SLOW: begin
        img[`PMCC_SLOW_DIVIDER_VALUE_LSB +: 3] = slow_divider_value_r;
        img[`PMCC_SLOW_BIT] = slow_bit_r;
        img[`PMCC_SLOW_PLL_OFF_BIT] = pll_off_r;
      end
      `PMCC_OFS_BUSDIV: begin
        img[`PMCC_BUSDIV_AHB_BIT] = ahb_half_r;
        img[`PMCC_BUSDIV_APB_BIT] = apb_half_r;
      end
      `PMCC_OFS_CLKOUT: img[`PMCC_CLKOUT_SEL_LSB +: 3] = clksel_r;
      `PMCC_OFS_LOCK: img[15:0] = lock_time_r;
      `PMCC_OFS_STATUS: begin
        case (state_r)
          ST_SLOW, ST_LOCK: img[`PMCC_STAT_MODE_LSB +: 2] = `PMCC_MODE_SLOW;
          ST_IDLE: img[`PMCC_STAT_MODE_LSB +: 2] = `PMCC_MODE_IDLE;
          ST_OFF, ST_WAKE: img[`PMCC_STAT_MODE_LSB +: 2] = `PMCC_MODE_OFF;
          default: img[`PMCC_STAT_MODE_LSB +: 2] = `PMCC_MODE_NORMAL;
        endcase
        img[`PMCC_STAT_LOCK_BIT] = (state_r == ST_LOCK);
        img[`PMCC_STAT_BATT_BIT] = batt_irq_r;
        img[`PMCC_STAT_WAKE_BIT] = wake_seen_r;
      end
      default: img = '0;
    endcase
    wimg = merge(img, avs_writedata, avs_byteenable);
    wait_nxt = ~((avs_read | avs_write) & wait_r);
    rdata_nxt = ((avs_read & wait_r) ? img : rdata_r);
    gate_nxt = gate_r;
    idle_bit_nxt = idle_bit_r;
    off_bit_nxt = off_bit_r;
    slow_divider_value_nxt = slow_divider_value_r;
    slow_bit_nxt = slow_bit_r;
    pll_off_nxt = pll_off_r;
    ahb_half_nxt = ahb_half_r;
    apb_half_nxt = apb_half_r;
    clksel_nxt = clksel_r;
    lock_time_nxt = lock_time_r;
    wake_seen_nxt = wake_seen_r;
    // Hardware clears command bits when the mode ends
    if (idle_done) begin
      idle_bit_nxt = 1'b0;
    end
    if (wake_done) begin
      off_bit_nxt = 1'b0;
    end
    if (wr_ok) begin
      case (avs_address)
        `PMCC_OFS_GATE: begin
          gate_nxt = wimg[`PMCC_GATE_PERIPH_LSB +: NUM_PERIPH];
          idle_bit_nxt = wimg[`PMCC_GATE_IDLE_BIT];
          off_bit_nxt = wimg[`PMCC_GATE_OFF_BIT];
        end
        `PMCC_OFS_SLOW: begin
          slow_divider_value_nxt = wimg[`PMCC_SLOW_DIVIDER_VALUE_LSB +: 3];
          slow_bit_nxt = wimg[`PMCC_SLOW_BIT];
          pll_off_nxt = wimg[`PMCC_SLOW_PLL_OFF_BIT];
        end
        `PMCC_OFS_BUSDIV: begin
          ahb_half_nxt = wimg[`PMCC_BUSDIV_AHB_BIT];
          apb_half_nxt = wimg[`PMCC_BUSDIV_APB_BIT];
        end
        `PMCC_OFS_CLKOUT: clksel_nxt = wimg[`PMCC_CLKOUT_SEL_LSB +: 3];
        `PMCC_OFS_LOCK: lock_time_nxt = wimg[15:0];
        `PMCC_OFS_STATUS: begin
          if (avs_byteenable[0] && avs_writedata[`PMCC_STAT_WAKE_BIT]) begin
            wake_seen_nxt = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // Set wins over a same-cycle clear
    if (wake_done) begin
      wake_seen_nxt = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wait_r <= 1'b1;
      rdata_r <= '0;
      gate_r <= NUM_PERIPH'(`PMCC_RST_PERIPH_GATE);
      idle_bit_r <= 1'b0;
      off_bit_r <= 1'b0;
      slow_divider_value_r <= '0;
      slow_bit_r <= 1'b0;
      pll_off_r <= 1'b0;
      ahb_half_r <= 1'b0;
      apb_half_r <= 1'b0;
      clksel_r <= `PMCC_RST_CLKOUT_SEL;
      lock_time_r <= 16'(LOCK_CYCLES);
      wake_seen_r <= 1'b0;
    end else begin
      wait_r <= wait_nxt;
      rdata_r <= rdata_nxt;
      gate_r <= gate_nxt;
      idle_bit_r <= idle_bit_nxt;
      off_bit_r <= off_bit_nxt;
      slow_divider_value_r <= slow_divider_value_nxt;
      slow_bit_r <= slow_bit_nxt;
      pll_off_r <= pll_off_nxt;
      ahb_half_r <= ahb_half_nxt;
      apb_half_r <= apb_half_nxt;
      clksel_r <= clksel_nxt;
      lock_time_r <= lock_time_nxt;
      wake_seen_r <= wake_seen_nxt;
    end
  end

  // Mode sequencer: only the defined transitions exist
  always_comb begin
    state_nxt = state_r;
    lock_cnt_nxt = lock_cnt_r;
    wake_cnt_nxt = wake_cnt_r;
    idle_done = 1'b0;
    wake_done = 1'b0;
    case (state_r)
      ST_NORMAL: begin
        if (off_bit_r) begin
          state_nxt = ST_OFF;
        end else if (idle_bit_r) begin
          state_nxt = ST_IDLE_WAIT;
        end else if (slow_bit_r) begin
          state_nxt = ST_SLOW;
        end
      end
      ST_SLOW: begin
        if (!slow_bit_r) begin
          // PLL counts as down if the bit or the last cycle's power-down says so
          if (pll_off_r || pll_pd_r) begin
            state_nxt = ST_LOCK;
            lock_cnt_nxt = lock_time_r;
          end else begin
            state_nxt = ST_NORMAL;
          end
        end
      end
      ST_LOCK: begin
        if (lock_cnt_r == '0) begin
          state_nxt = ST_NORMAL;
        end else begin
          lock_cnt_nxt = lock_cnt_r - 16'h0001;
        end
      end
      ST_IDLE_WAIT: begin
        if (cpu_irq) begin
          state_nxt = ST_NORMAL;
          idle_done = 1'b1;
        end else if (cpu_idle_ack) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (cpu_irq) begin
          state_nxt = ST_NORMAL;
          idle_done = 1'b1;
        end
      end
      ST_OFF: begin
        if (wake_any && battery_fault_n) begin
          state_nxt = ST_WAKE;
          wake_cnt_nxt = WW'(WAKE_RST_CYCLES - 1);
        end
      end
      ST_WAKE: begin
        if (wake_cnt_r == '0) begin
          state_nxt = ST_NORMAL;
          wake_done = 1'b1;
        end else begin
          wake_cnt_nxt = wake_cnt_r - WW'(1);
        end
      end
      default: state_nxt = ST_NORMAL;
    endcase
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= ST_NORMAL;
      lock_cnt_r <= '0;
      wake_cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      lock_cnt_r <= lock_cnt_nxt;
      wake_cnt_r <= wake_cnt_nxt;
    end
  end

  // Slow clock generator runs in slow mode and through the lock wait
  assign slow_run = (state_r == ST_SLOW) || (state_r == ST_LOCK);
  assign slow_cfg = '{slow_divider_value: slow_divider_value_r, ahb_half_option: ahb_half_r, apb_half_option: apb_half_r};

  pmcc_clkdiv u_clkdiv (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .run(slow_run),
    .cfg(slow_cfg),
    .cpu_tick(cpu_tick),
    .ahb_tick(ahb_tick),
    .apb_tick(apb_tick)
  );

  // Clock enables, power controls and interrupt
  always_comb begin
    cpu_en_nxt = 1'b0;
    cpu_pll_nxt = 1'b0;
    ahb_en_nxt = 1'b0;
    apb_en_nxt = 1'b0;
    case (state_r)
      ST_NORMAL, ST_IDLE_WAIT: begin
        cpu_en_nxt = 1'b1;
        cpu_pll_nxt = 1'b1;
        ahb_en_nxt = 1'b1;
        apb_en_nxt = 1'b1;
      end
      ST_SLOW, ST_LOCK: begin
        cpu_en_nxt = cpu_tick;
        ahb_en_nxt = ahb_tick;
        apb_en_nxt = apb_tick;
      end
      ST_IDLE: begin
        cpu_pll_nxt = 1'b1;
        ahb_en_nxt = 1'b1;
        apb_en_nxt = 1'b1;
      end
      default: ;
    endcase
    pclk_en_nxt = (state_r == ST_OFF || state_r == ST_WAKE) ? '0 : gate_r;
    pll_pd_nxt = (state_r == ST_SLOW) && pll_off_r;
    idle_req_nxt = (state_r == ST_IDLE_WAIT) || (state_r == ST_IDLE);
    pwr_en_nxt = (state_r != ST_OFF);
    int_rst_nxt = (state_r == ST_WAKE);
    batt_irq_nxt = ~battery_fault_n && (state_r != ST_OFF) && (state_r != ST_WAKE);
    case (clksel_r)
      `PMCC_CO_MPLL: clkout_nxt = main_pll_clock;
      `PMCC_CO_UPLL: clkout_nxt = usb_pll_clock;
      `PMCC_CO_CPU: clkout_nxt = cpu_en_r;
      `PMCC_CO_AHB: clkout_nxt = ahb_en_r;
      `PMCC_CO_APB: clkout_nxt = apb_en_r;
      `PMCC_CO_DIVIDED_CLOCK_ZERO: clkout_nxt = divided_clock_zero;
      default: clkout_nxt = 1'b0;
    endcase
  end

  // Pad control; power-off freezes function pins
  for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
    always_comb begin
      pad_out_nxt[p] = pad_out_r[p];
      pad_oe_nxt[p] = pad_oe_r[p];
      if (state_r == ST_OFF || state_r == ST_WAKE) begin
        if (pin_cfg[p].gpio_sel) begin
          pad_oe_nxt[p] = pin_cfg[p].gpio_dir_out && !pin_cfg[p].bidir;
          pad_out_nxt[p] = pin_cfg[p].gpio_data;
        end
      end else if (pin_cfg[p].gpio_sel) begin
        pad_oe_nxt[p] = pin_cfg[p].gpio_dir_out;
        pad_out_nxt[p] = pin_cfg[p].gpio_data;
      end else begin
        pad_oe_nxt[p] = pin_cfg[p].func_en;
        pad_out_nxt[p] = pin_cfg[p].func_level;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cpu_en_r <= 1'b0;
      cpu_pll_r <= 1'b0;
      ahb_en_r <= 1'b0;
      apb_en_r <= 1'b0;
      pclk_en_r <= '0;
      pll_pd_r <= 1'b0;
      idle_req_r <= 1'b0;
      pwr_en_r <= 1'b1;
      int_rst_r <= 1'b0;
      batt_irq_r <= 1'b0;
      clkout_r <= 1'b0;
      pad_out_r <= '0;
      pad_oe_r <= '0;
    end else begin
      cpu_en_r <= cpu_en_nxt;
      cpu_pll_r <= cpu_pll_nxt;
      ahb_en_r <= ahb_en_nxt;
      apb_en_r <= apb_en_nxt;
      pclk_en_r <= pclk_en_nxt;
      pll_pd_r <= pll_pd_nxt;
      idle_req_r <= idle_req_nxt;
      pwr_en_r <= pwr_en_nxt;
      int_rst_r <= int_rst_nxt;
      batt_irq_r <= batt_irq_nxt;
      clkout_r <= clkout_nxt;
      pad_out_r <= pad_out_nxt;
      pad_oe_r <= pad_oe_nxt;
    end
  end

  assign avs_readdata = rdata_r;
  assign avs_waitrequest = wait_r;
  assign cpu_core_clock_en = cpu_en_r;
  assign cpu_clock_from_pll = cpu_pll_r;
  assign ahb_clock_en = ahb_en_r;
  assign apb_clock_en = apb_en_r;
  assign periph_clock_en = pclk_en_r;
  assign pll_power_down = pll_pd_r;
  assign idle_request = idle_req_r;
  assign core_power_enable = pwr_en_r;
  assign internal_reset = int_rst_r;
  assign battery_irq = batt_irq_r;
  assign clock_out_port = clkout_r;
  assign pad_out = pad_out_r;
  assign pad_oe = pad_oe_r;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  a_off_power_drop: assert property (state_r == ST_OFF |=> !core_power_enable ##1 1'b1)
    else $error("core power enable high in power-off");
  a_off_exit_wake: assert property (($past(state_r) == ST_OFF && state_r != ST_OFF) |-> $past(wake_any))
    else $error("power-off left without wake input");
  a_batt_mask_wake: assert property ((state_r == ST_OFF && !battery_fault_n) |=> state_r == ST_OFF)
    else $error("wake taken during battery fault");
  a_lock_insert: assert property ((state_r == ST_SLOW && !slow_bit_r && pll_off_r) |=> state_r == ST_LOCK)
    else $error("lock wait not inserted");
  a_lock_slow_clk: assert property (state_r == ST_LOCK |=> !cpu_clock_from_pll && (cpu_core_clock_en == $past(cpu_tick)))
    else $error("cpu clock not slow during lock");
  a_pll_down_slow: assert property ((state_r == ST_SLOW && pll_off_r) |=> pll_power_down)
    else $error("pll not powered down in slow");
  a_idle_needs_ack: assert property ((state_r == ST_IDLE_WAIT && !cpu_idle_ack) |=> state_r != ST_IDLE)
    else $error("idle entered without ack");
  a_idle_irq_exit: assert property ((state_r == ST_IDLE && cpu_irq) |=> state_r == ST_NORMAL ##1 cpu_core_clock_en)
    else $error("interrupt did not end idle");
  a_idle_bus_run: assert property (state_r == ST_IDLE |=> !cpu_core_clock_en && ahb_clock_en && apb_clock_en)
    else $error("idle clock gating wrong");
  a_batt_irq_level: assert property ((!battery_fault_n && state_r == ST_NORMAL) |=> battery_irq)
    else $error("battery fault interrupt missing");
  a_clkout_reserved: assert property ((clksel_r > `PMCC_CO_DIVIDED_CLOCK_ZERO) |=> !clock_out_port)
    else $error("reserved clock out not low");
  a_wake_reset_on: assert property ((state_r == ST_OFF && state_nxt == ST_WAKE) |=> ##1 internal_reset[*8])
    else $error("internal reset not held after wake");

endmodule // pmcc_top

// ===== testbench/pmcc_partner.sv
`timescale 1ns/100ps
module pmcc_partner (
  input wire logic sys_clk,
  input wire logic idle_request,
  input wire logic wake,
  input wire logic batt_ok,
  output logic cpu_idle_ack,
  output logic [15:0] external_wake_inputs,
  output logic battery_fault_n
);
  // Wrapper acks an idle request one cycle later
  initial cpu_idle_ack = 1'b0;
  always @(posedge sys_clk) cpu_idle_ack <= idle_request;
  // Wake source and battery comparator levels
  assign external_wake_inputs = wake ? 16'h0100 : 16'h0000;
  assign battery_fault_n = batt_ok;
endmodule // pmcc_partner

// ===== testbench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import pmcc_pkg::*;
  logic sys_clk = 0, sys_rst = 1, rdq = 0, wrq = 0, cpu_irq = 0, wake = 0, batt_ok = 1;
  logic [4:0] adr = 0;
  logic [31:0] wd = 0, avs_readdata, rd;
  logic wreq, ack, bf_n, mpll = 0, upll = 0, dclk = 0, h, p;
  logic [15:0] wk;
  logic [2:0] v;
  pmcc_pin_cfg_t [7:0] pins = '0;
  logic cpu_en, from_pll, ahb_en, apb_en, pll_pd, idle_req, pwr, irst, birq, cko;
  logic [7:0] pclk_en, pado, padoe;
  logic [15:0] pad_last;
  int fails = 0, tests_run = 0, seed = 32'h2a2c, n, na, np, dv;
  always #10 sys_clk = ~sys_clk;
  pmcc_top #(.LOCK_CYCLES(20), .WAKE_RST_CYCLES(16)) i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .avs_address(adr), .avs_read(rdq), .avs_write(wrq), .avs_writedata(wd), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(wreq), .cpu_irq(cpu_irq), .cpu_idle_ack(ack),
    .external_wake_inputs(wk), .battery_fault_n(bf_n), .main_pll_clock(mpll), .usb_pll_clock(upll),
    .divided_clock_zero(dclk), .pin_cfg(pins), .cpu_core_clock_en(cpu_en), .cpu_clock_from_pll(from_pll),
    .ahb_clock_en(ahb_en), .apb_clock_en(apb_en), .periph_clock_en(pclk_en), .pll_power_down(pll_pd),
    .idle_request(idle_req), .core_power_enable(pwr), .internal_reset(irst), .battery_irq(birq),
    .clock_out_port(cko), .pad_out(pado), .pad_oe(padoe));
  pmcc_partner i_far (.sys_clk(sys_clk), .idle_request(idle_req), .wake(wake), .batt_ok(batt_ok),
    .cpu_idle_ack(ack), .external_wake_inputs(wk), .battery_fault_n(bf_n));
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One bus cycle, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    adr <= a;
    wd <= d;
    rdq <= !w;
    wrq <= w;
    do @(posedge sys_clk); while (wreq !== 1'b0);
    rd = avs_readdata;
    rdq <= 0;
    wrq <= 0;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
  endtask
  // Expected clock out level per select code
  function automatic logic exp_co(input int c);
    case (c)
      0: return mpll;
      1: return upll;
      2, 3, 4: return 1'b1;
      5: return dclk;
      default: return 1'b0;
    endcase
  endfunction
  // Expected {pad_oe, pad_out}; in power-off function pins keep last
  function automatic logic [15:0] exp_pad(input logic off, input logic [15:0] last);
    exp_pad = last;
    for (int i = 0; i < 8; i++) begin
      if (pins[i].gpio_sel) begin
        exp_pad[8+i] = pins[i].gpio_dir_out && !(off && pins[i].bidir);
        exp_pad[i] = pins[i].gpio_data;
      end else if (!off) begin
        exp_pad[8+i] = pins[i].func_en;
        exp_pad[i] = pins[i].func_level;
      end
    end
  endfunction
  task automatic results;
    $display("tests_run %0d fails %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    cyc(6);
    sys_rst <= 0;
    pins <= 48'($random(seed));
    bus(0, 5'h0c, 0); chk(rd, 0);
    bus(0, 5'h10, 0); chk(rd, 20);
    bus(0, 5'h18, 0); chk(rd, 0);
    bus(1, 5'h00, 32'ha500); cyc(3); chk(pclk_en, 8'ha5);
    chk({padoe, pado}, exp_pad(0, 16'h0));
    $display("registers done");
    for (int c = 0; c < 8; c++) begin
      {mpll, upll, dclk} <= 3'($random(seed));
      bus(1, 5'h0c, 32'(c) << 4);
      cyc(4);
      chk(cko, exp_co(c));
    end
    $display("clock out done");
    // Pass 0 random with PLL off, pass 1 divide by two, both halves, PLL on
    for (int k = 0; k < 2; k++) begin
      {v, h, p} = k ? 5'h07 : 5'($random(seed));
      dv = v ? 2 * v : 1;
      bus(1, 5'h08, 32'({h, p}));
      bus(1, 5'h04, 32'h10 | 32'(v));
      bus(1, 5'h04, (k ? 32'h10 : 32'h30) | 32'(v)); cyc(4); chk(pll_pd, !k);
      n = 0; na = 0; np = 0;
      repeat (4 * dv) begin
        @(posedge sys_clk);
        n += cpu_en; na += ahb_en; np += apb_en;
      end
      chk(n, 4);
      chk(na, h ? 2 : 4);
      chk(np, (h ? 2 : 4) >> p);
      bus(1, 5'h04, 0); cyc(2);
      if (!k) chk(from_pll, 0);
      bus(0, 5'h14, 0); chk(rd[2], !k);
      cyc(30); chk(from_pll, 1);
    end
    $display("slow done");
    bus(1, 5'h00, 32'hff04); cyc(6); chk(cpu_en, 0); chk(ahb_en, 1); chk(idle_req, 1);
    cpu_irq <= 1; cyc(1); cpu_irq <= 0; cyc(4); chk(cpu_en, 1);
    $display("idle done");
    batt_ok <= 0; cyc(3); chk(birq, 1);
    bus(1, 5'h00, 32'hff08); cyc(4); chk(pwr, 0); chk(pclk_en, 0); chk(birq, 0);
    pad_last = {padoe, pado};
    pins <= 48'($random(seed));
    cyc(3); chk({padoe, pado}, exp_pad(1, pad_last));
    wake <= 1; cyc(4); chk(pwr, 0);
    batt_ok <= 1; cyc(3); chk(irst, 1);
    wake <= 0; cyc(20); chk(irst, 0); chk(pwr, 1);
    $display("power off done");
    results();
  end
  // Watchdog against a hang
  initial begin
    cyc(20000);
    fails++;
    results();
  end
endmodule // tb_top
